// ---- esom_top.sv ----
// front-panel indicators and output-condition selection of the encoder
// assumes status inputs are synchronous to clk, apb master on the same clock
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - init indicator lit throughout initialisation, released when it ends
// - auto indicator follows automatic standard detection enable
// - with valid video, exactly one standard indicator matches detected standard
// - no input: fault flashes, both standard indicators off, no output without synchroniser
// - check or format error: fault flashes, detected standard steady
// - normal: fault off, standard steady, locked output with synchroniser, free-running without
// - selected reference missing: standard flashes, fault off, free-running
// - synchroniser, valid video and reference: locked output in any mode
// - synchroniser, video but no reference: correct free-running output
// - synchroniser, reference, no video: freeze repeats field, else corrupt
// - separate 525 and 625 references, active standard picks one
module esom_top
   import esom_pkg::*;
#(
   parameter int INIT_CNT  = INIT_CYCLES,
   parameter int FLASH_CNT = FLASH_CYCLES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // serial input status
   input  wire logic              video_present,
   input  wire logic              video_valid,
   input  wire logic              video_is_625,
   // references and synchroniser
   input  wire logic              fss_fitted,
   input  wire logic              ref525_present,
   input  wire logic              ref525_valid,
   input  wire logic              ref625_present,
   input  wire logic              ref625_valid,
   // front-panel indicators
   output logic                   power_indicator,
   output logic                   init_indicator,
   output logic                   auto_indicator,
   output logic                   fault_indicator,
   output logic                   std525_indicator,
   output logic                   std625_indicator,
   // output path control
   output logic      [2:0]        out_mode,
   output logic                   ref_select_625
);
   localparam int CNT_W = $clog2(INIT_CNT + 1);

   // pick the reference signal of the active standard
   function automatic logic ref_pick(input logic sel625, input logic r525,
                                     input logic r625);
      ref_pick = sel625 ? r625 : r525;
   endfunction

   esom_state_t      st_q;
   esom_state_t      st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic [31:0]      rdata_d;
   logic             tick;
   logic             flash;
   logic             run;
   logic             auto_en;
   logic             man625;
   logic             freeze_en;
   logic             act625;
   logic             vid_bad;
   logic             ref_here;
   logic             ref_good;
   logic             fault_d;
   logic             s525_d;
   logic             s625_d;
   esom_omode_t      mode_d;
   logic             acc;
   logic             hit_ctrl;
   logic             hit_stat;

   // flash timing shared by every blinking indicator
   esom_tick_div #(
      .DIV (FLASH_CNT)
   ) u_div (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   esom_flash u_flash (
      .clk   (clk),
      .rst   (rst),
      .tick  (tick),
      .flash (flash)
   );

   // initialisation timer after power-up reset
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         ST_INIT: begin
            if (cnt_q == CNT_W'(INIT_CNT - 1)) begin
               st_d = ST_RUN;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         ST_RUN: begin
            cnt_d = cnt_q;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q  <= ST_INIT;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign run       = (st_q == ST_RUN);
   assign auto_en   = ctrl_q[CTRL_AUTO_BIT];
   assign man625    = ctrl_q[CTRL_625_BIT];
   assign freeze_en = ctrl_q[CTRL_FREEZE_BIT];

   // active standard and input / reference qualification
   always_comb begin
      act625   = auto_en ? video_is_625 : man625;
      // manual standard that disagrees with the input is a format error
      vid_bad  = !video_valid || (!auto_en && (video_is_625 != man625));
      ref_here = ref_pick(act625, ref525_present, ref625_present);
      ref_good = ref_here &&
                 ref_pick(act625, ref525_valid, ref625_valid);
   end

   // indicator and output decision, in priority order
   always_comb begin
      fault_d = 1'b0;
      s525_d  = 1'b0;
      s625_d  = 1'b0;
      mode_d  = OM_NONE;
      if (run) begin
         if (!video_present) begin
            fault_d = flash;
            if (!fss_fitted) begin
               mode_d = OM_NONE;
            end else if (freeze_en && ref_good) begin
               mode_d = OM_FREEZE;
            end else begin
               mode_d = OM_CORRUPT;
            end
         end else if (vid_bad) begin
            fault_d = flash;
            s525_d  = !video_is_625;
            s625_d  = video_is_625;
            mode_d  = OM_CORRUPT;
         end else if (!ref_here) begin
            s525_d = !act625 & flash;
            s625_d = act625 & flash;
            mode_d = OM_FREE;
         end else begin
            s525_d = !act625;
            s625_d = act625;
            if (!fss_fitted) begin
               // without the synchroniser references are not used
               mode_d = OM_FREE;
            end else if (!ref_good) begin
               fault_d = flash;
               mode_d  = OM_CORRUPT;
            end else begin
               mode_d = OM_LOCKED;
            end
         end
      end
   end

   // indicators and output mode come straight from flip-flops
   always_ff @(posedge clk) begin
      if (rst) begin
         power_indicator  <= 1'b0;
         init_indicator   <= 1'b1;
         auto_indicator   <= 1'b0;
         fault_indicator  <= 1'b0;
         std525_indicator <= 1'b0;
         std625_indicator <= 1'b0;
         out_mode         <= OM_NONE;
         ref_select_625   <= 1'b0;
      end else begin
         power_indicator  <= 1'b1;
         init_indicator   <= (st_d == ST_INIT);
         auto_indicator   <= auto_en;
         fault_indicator  <= fault_d;
         std525_indicator <= s525_d;
         std625_indicator <= s625_d;
         out_mode         <= mode_d;
         ref_select_625   <= act625;
      end
   end

   // apb decode; zero wait states, unmapped addresses answer with error
   always_comb begin
      acc      = psel && penable;
      hit_ctrl = (paddr == REG_CTRL);
      hit_stat = (paddr == REG_STATUS);
      pready   = 1'b1;
      pslverr  = acc && !hit_ctrl && !hit_stat;
   end

   // control register written in the access cycle, read data captured in the setup cycle
   always_comb begin
      ctrl_d  = ctrl_q;
      rdata_d = prdata;
      if (acc && pwrite && hit_ctrl) begin
         ctrl_d = pwdata[CTRL_W-1:0];
      end
      if (psel && !penable && !pwrite) begin
         rdata_d = '0;
         if (hit_ctrl) begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
         end else if (hit_stat) begin
            rdata_d[STAT_INIT_BIT]   = init_indicator;
            rdata_d[STAT_FAULT_BIT]  = fault_indicator;
            rdata_d[STAT_525_BIT]    = std525_indicator;
            rdata_d[STAT_625_BIT]    = std625_indicator;
            rdata_d[STAT_AUTO_BIT]   = auto_indicator;
            rdata_d[STAT_MODE_LSB +: 3] = out_mode;
            rdata_d[STAT_DET625_BIT] = video_is_625;
            rdata_d[STAT_REF625_BIT] = ref_select_625;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         prdata <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         prdata <= rdata_d;
      end
   end

   // checks on the indicator and output decisions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // same-cycle form: the indicator falls on the very edge that enters run
   property p_init_hold;
      !run |-> init_indicator;
   endproperty
   a_init_hold: assert property (p_init_hold)
      else $error("init indicator dark during initialisation");

   property p_init_release;
      $rose(run) |-> ##1 !init_indicator [*3];
   endproperty
   a_init_release: assert property (p_init_release)
      else $error("init indicator still lit after initialisation");

   property p_auto;
      !$past(rst) |-> auto_indicator == $past(auto_en);
   endproperty
   a_auto: assert property (p_auto)
      else $error("auto indicator does not follow detection enable");

   property p_one_std;
      run && video_present && !vid_bad && ref_here
         |=> std525_indicator != std625_indicator;
   endproperty
   a_one_std: assert property (p_one_std)
      else $error("not exactly one standard indicator lit");

   property p_absent;
      run && !video_present |=> !std525_indicator && !std625_indicator
         && fault_indicator == $past(flash)
         && (out_mode != OM_NONE) == $past(fss_fitted);
   endproperty
   a_absent: assert property (p_absent)
      else $error("missing input not shown correctly");

   property p_err;
      run && video_present && vid_bad |=> fault_indicator == $past(flash)
         && std625_indicator == $past(video_is_625)
         && std525_indicator == !$past(video_is_625);
   endproperty
   a_err: assert property (p_err)
      else $error("input error not shown correctly");

   property p_locked;
      run && fss_fitted && video_present && !vid_bad && ref_good
         |=> !fault_indicator && out_mode == OM_LOCKED;
   endproperty
   a_locked: assert property (p_locked)
      else $error("valid video and reference not locked");

   property p_refmiss;
      run && video_present && !vid_bad && !ref_here
         |=> !fault_indicator && out_mode == OM_FREE
         && (std525_indicator | std625_indicator) == $past(flash);
   endproperty
   a_refmiss: assert property (p_refmiss)
      else $error("missing reference not shown as free running");

   property p_freeze;
      run && fss_fitted && !video_present && ref_good
         |=> out_mode == ($past(freeze_en) ? OM_FREEZE : OM_CORRUPT);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("freeze option not honoured");

   property p_corrupt;
      run && fss_fitted && video_present && (vid_bad || !ref_good)
         && ref_here |=> out_mode == OM_CORRUPT;
   endproperty
   a_corrupt: assert property (p_corrupt)
      else $error("invalid input not flagged as corrupted");

   property p_refsel;
      run && video_present ##1 1 |-> ref_select_625 == $past(act625);
   endproperty
   a_refsel: assert property (p_refsel)
      else $error("reference of wrong standard selected");
endmodule
`default_nettype wire

// ---- esom_pkg.sv ----
// constants and types shared by the encoder status and output-mode logic
// assumes a single 40 MHz system clock and a synchronous power-up reset
package esom_pkg;

   // clock and timing
   localparam int CLK_HZ        = 40_000_000;
   localparam int INIT_TIME_MS  = 500;
   localparam int FLASH_HALF_MS = 250;
   localparam int INIT_CYCLES   = ((CLK_HZ / 1000) * INIT_TIME_MS);
   localparam int FLASH_CYCLES  = ((CLK_HZ / 1000) * FLASH_HALF_MS);

   // register map, byte addresses on the apb bus
   localparam int             ADDR_W     = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;

   // control register fields and reset value
   localparam int         CTRL_AUTO_BIT   = 0;
   localparam int         CTRL_625_BIT    = 1;
   localparam int         CTRL_FREEZE_BIT = 2;
   localparam int         CTRL_W          = 3;
   localparam logic [2:0] CTRL_RESET      = 3'h1;

   // status register fields
   localparam int STAT_INIT_BIT   = 0;
   localparam int STAT_FAULT_BIT  = 1;
   localparam int STAT_525_BIT    = 2;
   localparam int STAT_625_BIT    = 3;
   localparam int STAT_AUTO_BIT   = 4;
   localparam int STAT_MODE_LSB   = 5;
   localparam int STAT_DET625_BIT = 8;
   localparam int STAT_REF625_BIT = 9;

   // module life cycle
   typedef enum logic [0:0] {
      ST_INIT = 1'b0,
      ST_RUN  = 1'b1
   } esom_state_t;

   // what the composite output carries
   typedef enum logic [2:0] {
      OM_NONE    = 3'h0,
      OM_LOCKED  = 3'h1,
      OM_FREE    = 3'h3,
      OM_CORRUPT = 3'h2,
      OM_FREEZE  = 3'h6
   } esom_omode_t;

endpackage

// ---- esom_tick_div.sv ----
// divider giving a one-cycle enable pulse every DIV clocks
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module esom_tick_div #(
   parameter int DIV = 4
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // slow enable
   output logic      tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          tick_d;

   // wrap at DIV-1 and pulse on the wrap
   always_comb begin
      tick_d = (cnt_q == CW'(DIV - 1));
      cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule
`default_nettype wire

// ---- esom_flash.sv ----
// square wave for flashing indicators, toggled by a slow enable
// assumes the enable comes from a divider on the same clock
`timescale 1ns/1ps
`default_nettype none
module esom_flash (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // half-period enable
   input  wire logic tick,
   // flash level, starts lit
   output logic      flash
);
   logic flash_d;

   // all flashing indicators share this phase so they blink together
   always_comb begin
      flash_d = tick ? ~flash : flash;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flash <= 1'b1;
      end else begin
         flash <= flash_d;
      end
   end
endmodule
`default_nettype wire

// ---- esom_src_model.sv ----
// model of the serial video source and the two black-burst references
// assumes the bench sets the scene codes just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module esom_src_model (
   // clock
   input  wire logic       clk,
   // scene codes: 0 absent, 1 present and valid, 2 present but invalid
   input  wire logic [1:0] vid_sel,
   input  wire logic       vid_625,
   input  wire logic [1:0] r525_sel,
   input  wire logic [1:0] r625_sel,
   // status lines into the encoder
   output logic            video_present,
   output logic            video_valid,
   output logic            video_is_625,
   output logic            ref525_present,
   output logic            ref525_valid,
   output logic            ref625_present,
   output logic            ref625_valid
);
   logic junk_q = 1'b0;

   // lines of an absent source wander every cycle, never hold a stale value
   always @(posedge clk) begin
      junk_q         <= ~junk_q;
      video_present  <= (vid_sel != 2'h0);
      video_valid    <= (vid_sel == 2'h0) ? junk_q : (vid_sel == 2'h1);
      video_is_625   <= (vid_sel == 2'h0) ? ~junk_q : vid_625;
      // two separate reference feeds
      ref525_present <= (r525_sel != 2'h0);
      ref525_valid   <= (r525_sel == 2'h0) ? junk_q : (r525_sel == 2'h1);
      ref625_present <= (r625_sel != 2'h0);
      ref625_valid   <= (r625_sel == 2'h0) ? ~junk_q : (r625_sel == 2'h1);
   end
endmodule
`default_nettype wire

// ---- encoder_status_and_output_mode_tb.sv ----
// self-checking bench for the indicator and output-mode logic
// assumes short init and flash counts so the full sweep stays quick
`timescale 1ns/1ps
`default_nettype none
module encoder_status_and_output_mode_tb;
   import esom_pkg::*;
   localparam int INIT_N  = 20;
   localparam int FLASH_N = 4;
   logic              clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              video_present, video_valid, video_is_625, fss_fitted;
   logic              ref525_present, ref525_valid, ref625_present;
   logic              ref625_valid, power_indicator, init_indicator, er;
   logic              auto_indicator, fault_indicator, ref_select_625;
   logic              std525_indicator, std625_indicator, vid_625;
   logic [2:0]        out_mode;
   logic [1:0]        vid_sel, r525_sel, r625_sel;
   int                bad_count, checked, cycles, ct, fs, v, d, r5, r6;

   esom_top #(.INIT_CNT(INIT_N), .FLASH_CNT(FLASH_N)) i_dut (.clk, .rst,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .video_present, .video_valid, .video_is_625, .fss_fitted,
      .ref525_present, .ref525_valid, .ref625_present, .ref625_valid,
      .power_indicator, .init_indicator, .auto_indicator, .fault_indicator,
      .std525_indicator, .std625_indicator, .out_mode, .ref_select_625);
   esom_src_model i_src (.clk, .vid_sel, .vid_625, .r525_sel, .r625_sel,
      .video_present, .video_valid, .video_is_625, .ref525_present,
      .ref525_valid, .ref625_present, .ref625_valid);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard sized well above the full sweep
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready, takes data at that edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // reference model; classes 0 off, 1 steady, 2 flashing; rs 2 = any
   task automatic model(input int ct, fs, v, d, r5, r6,
                        output int f, s5, s6, m, rs);
      int au, act, r, ss;
      au  = ct & 1;
      act = au ? d : (ct >> 1) & 1;
      r   = act ? r6 : r5;
      rs  = (v == 0 && au) ? 2 : act;
      f   = 0;
      ss  = 0;
      if (v == 0) begin
         f = 2;
         m = !fs ? 0 : ((ct & 4) && r == 1) ? 6 : 2;
      end else if (v == 2 || act != d) begin
         f   = 2;
         ss  = 1;
         act = d;
         m   = 2;
      end else if (r == 0) begin
         ss = 2;
         m  = 3;
      end else begin
         ss = 1;
         m  = !fs ? 3 : (r == 2) ? 2 : 1;
         f  = (fs && r == 2) ? 2 : 0;
      end
      s5 = act ? 0 : ss;
      s6 = act ? ss : 0;
   endtask

   function automatic logic [2:0] mark(input logic x);
      return (x === 1'b1) ? 3'h2 : (x === 1'b0) ? 3'h1 : 3'h4;
   endfunction

   function automatic int cls(input logic [2:0] s);
      return (s == 3'h3) ? 2 : (s == 3'h2) ? 1 : (s == 3'h1) ? 0 : 3;
   endfunction

   task automatic run_case();
      int f, s5, s6, m, rs;
      logic [2:0] sf, sa, sb;
      model(ct, fs, v, d, r5, r6, f, s5, s6, m, rs);
      apb(1'b1, REG_CTRL, 32'(ct));
      vid_sel    <= 2'(v);
      vid_625    <= d[0];
      r525_sel   <= 2'(r5);
      r625_sel   <= 2'(r6);
      fss_fitted <= fs[0];
      repeat (4) @(posedge clk);
      sf = 3'h0;
      sa = 3'h0;
      sb = 3'h0;
      // window longer than a full flash period shows steady from flashing
      repeat (2 * FLASH_N + 2) begin
         @(posedge clk);
         sf |= mark(fault_indicator);
         sa |= mark(std525_indicator);
         sb |= mark(std625_indicator);
         chk(32'(out_mode), m);
      end
      chk(cls(sf), f);
      chk(cls(sa), s5);
      chk(cls(sb), s6);
      chk(32'(auto_indicator), ct & 1);
      if (rs != 2) chk(32'(ref_select_625), rs);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rd[7:4]), (m << 1) | (ct & 1));
   endtask

   initial begin
      void'($urandom(32'hb1c945cf));
      {psel, penable, pwrite, paddr, pwdata, vid_625} = '0;
      {bad_count, checked, cycles} = '0;
      rst        = 1'b1;
      fss_fitted = 1'b1;
      vid_sel    = 2'h1;
      r525_sel   = 2'h1;
      r625_sel   = 2'h1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 32'h1);
      chk({power_indicator, auto_indicator, init_indicator}, 32'h7);
      chk({fault_indicator, out_mode}, 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h1);
      repeat (INIT_N - 10) @(posedge clk);
      chk(32'(init_indicator), 32'h1);
      repeat (6) @(posedge clk);
      chk(32'(init_indicator), 32'h0);
      // unmapped place errors; status is read-only
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, REG_STATUS, 32'hffffffff);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(32'(er), 32'h0);
      chk(rd, 32'h1);
      // every mode, standard, video and reference combination, except absent video in auto mode with unequal references
      for (int k = 0; k < 864; k++) begin
         ct = k % 8;
         fs = (k / 8) % 2;
         v  = (k / 16) % 3;
         d  = (k / 48) % 2;
         r5 = (k / 96) % 3;
         r6 = (k / 288) % 3;
         if (!(v == 0 && (ct & 1) && r5 != r6)) run_case();
      end
      repeat (60) begin
         ct = $urandom % 8;
         fs = $urandom % 2;
         v  = $urandom % 3;
         d  = $urandom % 2;
         r5 = $urandom % 3;
         r6 = (v == 0 && (ct & 1)) ? r5 : $urandom % 3;
         run_case();
      end
      wrap_up();
   end
endmodule
`default_nettype wire
